// File: rtl/plc_defs.vh
// constants for the port and lane configuration block
`ifndef PLC_DEFS_VH
`define PLC_DEFS_VH

// ==========================================
// register offsets
`define PLC_REG_CLKEN      12'h1d8
`define PLC_REG_PORTCFG    12'h1e0
`define PLC_REG_LINKSTAT   12'h1e4
`define PLC_REG_GPIOCTL    12'h1e8
`define PLC_REG_GPIOPWM    12'h1ec
`define PLC_REG_GPIOEVT    12'h1f0
`define PLC_REG_DEVNUM     12'h1f4

// ==========================================
// field positions
`define PLC_CLKEN_LSB      8
`define PLC_CLKEN_MSB      10
`define PLC_PCFG_MODE      0
`define PLC_PCFG_EN_LSB    4
`define PLC_PCFG_SPD_LSB   8
`define PLC_STAT_SRC_BIT   16

// ==========================================
// reset values
`define PLC_CLKEN_RST      3'h7
`define PLC_PORT_EN_RST    4'hf
`define PLC_SPD_RST        4'hf
`define PLC_PWM_PER_RST    8'hff
`define PLC_PWM_DUTY_RST   8'h80

// ==========================================
// port widths
`define PLC_W_NONE         2'h0
`define PLC_W_X1           2'h1
`define PLC_W_X2           2'h2

// ==========================================
// timing
`define PLC_CLK_MHZ        200
`define PLC_TRAIN_NS       2000
`define PLC_TRAIN_CYC      ((`PLC_TRAIN_NS * `PLC_CLK_MHZ) / 1000)
`define PLC_PWM_TICK_NS    1000
`define PLC_PWM_TICK_CYC   ((`PLC_PWM_TICK_NS * `PLC_CLK_MHZ) / 1000)

`endif

// File: rtl/plc_link_train.v
// per-port link training with width fallback and lane reversal
`timescale 1ns/1ps
`include "plc_defs.vh"

module plc_link_train (
   // clock and reset
   input  wire       clk,
   input  wire       rst,
   // control
   input  wire       start,
   input  wire [1:0] prog_w,
   input  wire       partner_x2,
   input  wire [1:0] lane_ok,
   // result
   output wire       link_up,
   output wire [1:0] link_w,
   output wire       lane_rev
);

   localparam S_IDLE = 3'h0;
   localparam S_TRY2 = 3'h1;
   localparam S_TRY1 = 3'h2;
   localparam S_TRYR = 3'h3;
   localparam S_UP   = 3'h4;
   localparam S_FAIL = 3'h5;
   localparam integer ATT_LAST_I = `PLC_TRAIN_CYC - 1;
   localparam [8:0]   ATT_LAST   = ATT_LAST_I[8:0];

   reg [2:0] state_r;
   reg [8:0] cnt_r;
   reg       up_r;
   reg [1:0] w_r;
   reg       rev_r;

   wire done     = (cnt_r == ATT_LAST);
   wire [2:0] first_try = (prog_w == `PLC_W_X2) ? S_TRY2 :
                          (prog_w == `PLC_W_X1) ? S_TRY1 : S_IDLE;
   // the lane the x1 link runs on, or both for x2
   wire lost = (w_r == `PLC_W_X2) ? ~(&lane_ok) : ~lane_ok[rev_r];

   // ==========================================
   // training sequence
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= S_IDLE;
         cnt_r   <= 9'h000;
         up_r    <= 1'b0;
         w_r     <= `PLC_W_NONE;
         rev_r   <= 1'b0;
      end else if (start) begin
         state_r <= first_try;
         cnt_r   <= 9'h000;
         up_r    <= 1'b0;
         w_r     <= `PLC_W_NONE;
         rev_r   <= 1'b0;
      end else begin
         cnt_r <= done ? 9'h000 : cnt_r + 9'h001;
         case (state_r)
            S_TRY2: begin
               // never wider than the narrower end
               if (done && partner_x2 && (&lane_ok)) begin
                  state_r <= S_UP;
                  up_r    <= 1'b1;
                  w_r     <= `PLC_W_X2;
               end else if (done) begin
                  state_r <= S_TRY1; // broken lane dropped, fall to x1
               end
            end
            S_TRY1: begin
               if (done && lane_ok[0]) begin
                  state_r <= S_UP;
                  up_r    <= 1'b1;
                  w_r     <= `PLC_W_X1;
               end else if (done) begin
                  state_r <= S_TRYR; // lowest lane dead, reverse and retry
               end
            end
            S_TRYR: begin
               // partner lane 0 must sit on our top lane here
               if (done && lane_ok[1]) begin
                  state_r <= S_UP;
                  up_r    <= 1'b1;
                  w_r     <= `PLC_W_X1;
                  rev_r   <= 1'b1;
               end else if (done) begin
                  state_r <= S_FAIL;
               end
            end
            S_UP: begin
               // a lane lost while up retrains from the programmed width
               if (lost) begin
                  state_r <= first_try;
                  up_r    <= 1'b0;
                  w_r     <= `PLC_W_NONE;
                  rev_r   <= 1'b0;
               end
               cnt_r <= 9'h000;
            end
            default: begin
               cnt_r <= 9'h000;
            end
         endcase
      end
   end

   assign link_up  = up_r;
   assign link_w   = w_r;
   assign lane_rev = rev_r;

endmodule // plc_link_train

// File: rtl/plc_gpio.v
// four general-purpose pins with edge events and pwm output
`timescale 1ns/1ps
`include "plc_defs.vh"

module plc_gpio (
   // clock and reset
   input  wire       clk,
   input  wire       rst,
   // pins
   input  wire [3:0] pin_in,
   output wire [3:0] pin_out,
   output wire [3:0] pin_oe_n,
   // control
   input  wire [3:0] dir_out,
   input  wire [3:0] out_val,
   input  wire [3:0] pwm_en,
   input  wire [3:0] rise_en,
   input  wire [3:0] fall_en,
   input  wire [7:0] pwm_per,
   input  wire [7:0] pwm_duty,
   // events
   output wire [3:0] evt
);

   localparam integer TICK_LAST_I = `PLC_PWM_TICK_CYC - 1;
   localparam [7:0]   TICK_LAST   = TICK_LAST_I[7:0];

   reg  [7:0] div_r;
   reg  [7:0] pwm_cnt_r;
   wire       tick = (div_r == TICK_LAST);
   // shared pwm phase keeps all pins aligned, at the cost of one period per block
   wire       pwm_hi = (pwm_cnt_r < pwm_duty);

   // ==========================================
   // divider and pwm phase
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         div_r     <= 8'h00;
         pwm_cnt_r <= 8'h00;
      end else begin
         div_r <= tick ? 8'h00 : div_r + 8'h01;
         if (tick) begin
            pwm_cnt_r <= (pwm_cnt_r >= pwm_per) ? 8'h00 : pwm_cnt_r + 8'h01;
         end
      end
   end

   // ==========================================
   // per pin
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_pin
         reg prev_r;
         reg evt_r;
         reg out_r;
         reg oe_n_r;
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               prev_r <= 1'b0;
               evt_r  <= 1'b0;
               out_r  <= 1'b0;
               oe_n_r <= 1'b1;
            end else begin
               prev_r <= pin_in[i];
               // rising or falling edge raises the event
               evt_r  <= ~dir_out[i] & ((rise_en[i] & pin_in[i] & ~prev_r) |
                                        (fall_en[i] & ~pin_in[i] & prev_r));
               // constant level or pwm waveform
               out_r  <= pwm_en[i] ? pwm_hi : out_val[i];
               oe_n_r <= ~dir_out[i];
            end
         end
         assign evt[i]      = evt_r;
         assign pin_out[i]  = out_r;
         assign pin_oe_n[i] = oe_n_r;
      end
   endgenerate

endmodule // plc_gpio

// File: rtl/plc_port_lane_cfg.v
// port and lane grouping, training control, clock output enables and gpio
`timescale 1ns/1ps
`include "plc_defs.vh"

// Operation
// - Initial port widths follow the strap level caught after reset.
// - Strap 0 gives four x1 ports; strap 1 gives x2 port 0, no port 1, x1 ports 2 and 3.
// - A port setup loaded from the config memory after reset replaces the strap setup.
// - The management register port may rewrite the port setup at any time after the strap is caught.
// - Training narrows a port so the link never exceeds the narrower end.
// - A broken lane is dropped, and an x2 port may settle at x1.
// - When x1 fails because the lowest lane is dead, lanes are reversed and training repeats.
// - Each port picks 2.5 or 5.0 GT/s on its own.
// - A port not configured and enabled ignores config accesses.
// - Port 0 is upstream; downstream bridges report device numbers 1, 2 and 3.
// - The upstream bridge takes whatever device number the upstream side assigns.
// - A gpio input flags rising or falling edges; an output drives a level or pwm.
// - Each downstream port has a clock output pair stopped by clearing its enable bit.
// - Each port trains on its own engine; the config load and each later port setup write restart all ports together.
module plc_port_lane_cfg (
   // clock and reset
   input  wire        REF_CLK,
   input  wire        SYS_RST,
   // strap
   input  wire        PORT_WIDTH_STRAP,
   // config memory loader
   input  wire        CFG_LOAD_DONE,
   input  wire        CFG_LOAD_HAS_PORTCFG,
   input  wire        CFG_LOAD_PORTCFG,
   input  wire        CFG_LOAD_HAS_CLKEN,
   input  wire [2:0]  CFG_LOAD_CLKEN,
   // management register port
   input  wire [11:0] REG_ADDR,
   input  wire        REG_WR,
   input  wire        REG_RD,
   input  wire [31:0] REG_WDATA,
   output wire [31:0] REG_RDATA,
   output wire        REG_RDATA_VALID,
   // lanes and partners
   input  wire [3:0]  LANE_OK,
   input  wire [3:0]  PARTNER_X2,
   input  wire [3:0]  PARTNER_GEN2,
   // link results
   output wire [3:0]  LINK_UP,
   output wire [3:0]  LINK_GEN2,
   output wire [3:0]  PORT_CFG_RESPOND,
   // bridge numbering
   input  wire        UP_DEVNUM_LOAD,
   input  wire [4:0]  UP_DEVNUM,
   output wire [19:0] BRIDGE_DEVNUM,
   // clock output pairs
   output wire [2:0]  CLK_OUT_PAIR_EN,
   // gpio pins
   input  wire [3:0]  GPIO_IN,
   output wire [3:0]  GPIO_OUT,
   output wire [3:0]  GPIO_OE_N
);

   // ==========================================
   // state
   reg        strap_taken_r;
   reg        cfg_mode_r;
   reg        cfg_src_mem_r;
   reg        loaded_r;
   reg        start_r;
   reg [3:0]  port_en_r;
   reg [3:0]  spd_r;
   reg [2:0]  clken_r;
   reg [3:0]  gpio_dir_r;
   reg [3:0]  gpio_val_r;
   reg [3:0]  gpio_pwm_r;
   reg [3:0]  gpio_rise_r;
   reg [3:0]  gpio_fall_r;
   reg [7:0]  pwm_per_r;
   reg [7:0]  pwm_duty_r;
   reg [3:0]  gpio_evt_r;
   reg [4:0]  up_devnum_r;
   reg [3:0]  gen2_r;
   reg [3:0]  respond_r;
   reg [31:0] rdata_r;
   reg        rvalid_r;
   reg [31:0] rdata_nxt;

   wire [3:0] up_w;
   wire [7:0] w_w;
   wire [3:0] rev_w;
   wire [3:0] gpio_evt;
   wire [7:0] prog_w;
   wire [3:0] configured;

   wire wr_clken = REG_WR && (REG_ADDR == `PLC_REG_CLKEN);
   wire wr_pcfg  = REG_WR && (REG_ADDR == `PLC_REG_PORTCFG);

   // ==========================================
   // programmed width per port
   assign prog_w[1:0] = cfg_mode_r ? `PLC_W_X2 : `PLC_W_X1;
   assign prog_w[3:2] = cfg_mode_r ? `PLC_W_NONE : `PLC_W_X1;
   assign prog_w[5:4] = `PLC_W_X1;
   assign prog_w[7:6] = `PLC_W_X1;

   genvar p;
   generate
      for (p = 0; p < 4; p = p + 1) begin : g_cfg
         assign configured[p] = (prog_w[2*p+1 -: 2] != `PLC_W_NONE);
      end
   endgenerate

   // ==========================================
   // port setup source and training start
   // training waits for the loader so a memory setup is never undone mid-link
   always @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         strap_taken_r <= 1'b0;
         cfg_mode_r    <= 1'b0;
         cfg_src_mem_r <= 1'b0;
         loaded_r      <= 1'b0;
         start_r       <= 1'b0;
      end else begin
         start_r <= 1'b0;
         if (!strap_taken_r) begin
            strap_taken_r <= 1'b1;
            cfg_mode_r    <= PORT_WIDTH_STRAP;
         end else if (wr_pcfg) begin
            cfg_mode_r    <= REG_WDATA[`PLC_PCFG_MODE];
            cfg_src_mem_r <= 1'b0;
            start_r       <= loaded_r;
         end else if (!loaded_r && CFG_LOAD_DONE) begin
            loaded_r <= 1'b1;
            start_r  <= 1'b1;
            if (CFG_LOAD_HAS_PORTCFG) begin
               cfg_mode_r    <= CFG_LOAD_PORTCFG;
               cfg_src_mem_r <= 1'b1;
            end // else the strap setup stays
         end
      end
   end

   // ==========================================
   // control registers
   always @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         port_en_r   <= `PLC_PORT_EN_RST;
         spd_r       <= `PLC_SPD_RST;
         clken_r     <= `PLC_CLKEN_RST;
         gpio_dir_r  <= 4'h0;
         gpio_val_r  <= 4'h0;
         gpio_pwm_r  <= 4'h0;
         gpio_rise_r <= 4'h0;
         gpio_fall_r <= 4'h0;
         pwm_per_r   <= `PLC_PWM_PER_RST;
         pwm_duty_r  <= `PLC_PWM_DUTY_RST;
      end else begin
         if (wr_clken) begin
            clken_r <= REG_WDATA[`PLC_CLKEN_MSB:`PLC_CLKEN_LSB];
         end else if (!loaded_r && CFG_LOAD_DONE && CFG_LOAD_HAS_CLKEN) begin
            clken_r <= CFG_LOAD_CLKEN;
         end
         if (wr_pcfg) begin
            port_en_r <= REG_WDATA[`PLC_PCFG_EN_LSB+3:`PLC_PCFG_EN_LSB];
            spd_r     <= REG_WDATA[`PLC_PCFG_SPD_LSB+3:`PLC_PCFG_SPD_LSB];
         end
         if (REG_WR && (REG_ADDR == `PLC_REG_GPIOCTL)) begin
            gpio_dir_r  <= REG_WDATA[3:0];
            gpio_val_r  <= REG_WDATA[7:4];
            gpio_pwm_r  <= REG_WDATA[11:8];
            gpio_rise_r <= REG_WDATA[15:12];
            gpio_fall_r <= REG_WDATA[19:16];
         end
         if (REG_WR && (REG_ADDR == `PLC_REG_GPIOPWM)) begin
            pwm_per_r  <= REG_WDATA[7:0];
            pwm_duty_r <= REG_WDATA[15:8];
         end
      end
   end

   // ==========================================
   // gpio event flags, write one to clear; a new event beats the clear
   always @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         gpio_evt_r <= 4'h0;
      end else if (REG_WR && (REG_ADDR == `PLC_REG_GPIOEVT)) begin
         gpio_evt_r <= (gpio_evt_r & ~REG_WDATA[3:0]) | gpio_evt;
      end else begin
         gpio_evt_r <= gpio_evt_r | gpio_evt;
      end
   end

   // ==========================================
   // per-port training, each port on its own engine
   generate
      for (p = 0; p < 4; p = p + 1) begin : g_port
         wire [1:0] lok;
         if (p == 0) begin : g_p0
            assign lok = cfg_mode_r ? LANE_OK[1:0] : {LANE_OK[0], LANE_OK[0]};
         end else begin : g_pn
            assign lok = {LANE_OK[p], LANE_OK[p]};
         end
         plc_link_train u_train (
            .clk        (REF_CLK),
            .rst        (SYS_RST),
            .start      (start_r),
            .prog_w     (port_en_r[p] ? prog_w[2*p+1 -: 2] : `PLC_W_NONE),
            .partner_x2 (PARTNER_X2[p]),
            .lane_ok    (lok),
            .link_up    (up_w[p]),
            .link_w     (w_w[2*p+1 -: 2]),
            .lane_rev   (rev_w[p])
         );
      end
   endgenerate

   // ==========================================
   // speed, visibility and bridge numbering
   always @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         gen2_r      <= 4'h0;
         respond_r   <= 4'h0;
         up_devnum_r <= 5'h00;
      end else begin
         gen2_r    <= up_w & spd_r & PARTNER_GEN2;
         respond_r <= configured & port_en_r;
         if (UP_DEVNUM_LOAD) begin
            up_devnum_r <= UP_DEVNUM;
         end
      end
   end

   // downstream bridges carry their port number
   assign BRIDGE_DEVNUM = {5'h03, 5'h02, 5'h01, up_devnum_r};

   // ==========================================
   // register read
   always @* begin
      rdata_nxt = 32'h0000_0000;
      if (REG_ADDR == `PLC_REG_CLKEN) begin
         rdata_nxt[`PLC_CLKEN_MSB:`PLC_CLKEN_LSB] = clken_r;
      end else if (REG_ADDR == `PLC_REG_PORTCFG) begin
         rdata_nxt[`PLC_PCFG_MODE] = cfg_mode_r;
         rdata_nxt[`PLC_PCFG_EN_LSB+3:`PLC_PCFG_EN_LSB] = port_en_r;
         rdata_nxt[`PLC_PCFG_SPD_LSB+3:`PLC_PCFG_SPD_LSB] = spd_r;
      end else if (REG_ADDR == `PLC_REG_LINKSTAT) begin
         rdata_nxt[15:0] = {gen2_r[3], rev_w[3], w_w[7:6], gen2_r[2], rev_w[2], w_w[5:4],
                            gen2_r[1], rev_w[1], w_w[3:2], gen2_r[0], rev_w[0], w_w[1:0]};
         rdata_nxt[`PLC_STAT_SRC_BIT] = cfg_src_mem_r;
      end else if (REG_ADDR == `PLC_REG_GPIOCTL) begin
         rdata_nxt[19:0] = {gpio_fall_r, gpio_rise_r, gpio_pwm_r, gpio_val_r, gpio_dir_r};
      end else if (REG_ADDR == `PLC_REG_GPIOPWM) begin
         rdata_nxt[15:0] = {pwm_duty_r, pwm_per_r};
      end else if (REG_ADDR == `PLC_REG_GPIOEVT) begin
         rdata_nxt[3:0] = gpio_evt_r;
      end else if (REG_ADDR == `PLC_REG_DEVNUM) begin
         rdata_nxt[19:0] = BRIDGE_DEVNUM;
      end
   end

   always @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rdata_r  <= 32'h0000_0000;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= REG_RD;
         if (REG_RD) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   // ==========================================
   // gpio
   plc_gpio u_gpio (
      .clk      (REF_CLK),
      .rst      (SYS_RST),
      .pin_in   (GPIO_IN),
      .pin_out  (GPIO_OUT),
      .pin_oe_n (GPIO_OE_N),
      .dir_out  (gpio_dir_r),
      .out_val  (gpio_val_r),
      .pwm_en   (gpio_pwm_r),
      .rise_en  (gpio_rise_r),
      .fall_en  (gpio_fall_r),
      .pwm_per  (pwm_per_r),
      .pwm_duty (pwm_duty_r),
      .evt      (gpio_evt)
   );

   // ==========================================
   // outputs
   assign REG_RDATA        = rdata_r;
   assign REG_RDATA_VALID  = rvalid_r;
   assign LINK_UP          = up_w;
   assign LINK_GEN2        = gen2_r;
   assign PORT_CFG_RESPOND = respond_r;
   assign CLK_OUT_PAIR_EN  = clken_r;

endmodule // plc_port_lane_cfg

// File: verification/plc_link_partner.sv
// link partner model: per-lane presence, width and speed capability
`timescale 1ns/1ps
module plc_link_partner (
   // clock and reset
   input  wire       clk,
   input  wire       rst,
   // scenario controls
   input  wire [3:0] broken,
   input  wire [3:0] x2_cap,
   input  wire [3:0] gen2_cap,
   // toward the block
   output wire [3:0] lane_ok,
   output wire [3:0] partner_x2,
   output wire [3:0] partner_gen2
);
   // ==========================================
   // lane receivers
   reg [3:0] lane_ok_r;
   // a sound lane answers a cycle late, so the block never sees a same-edge change
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         lane_ok_r <= 4'h0;
      end else begin
         lane_ok_r <= ~broken;
      end
   end
   assign lane_ok      = lane_ok_r;
   assign partner_x2   = x2_cap;
   assign partner_gen2 = gen2_cap;
endmodule // plc_link_partner

// File: verification/plc_port_lane_cfg_chk.sv
// assertions on the ports of the port and lane configuration block
`timescale 1ns/1ps
module plc_port_lane_cfg_chk (
   // clock and reset
   input wire        REF_CLK,
   input wire        SYS_RST,
   // register port and loader
   input wire        CFG_LOAD_DONE,
   input wire [11:0] REG_ADDR,
   input wire        REG_WR,
   input wire        REG_RD,
   input wire [31:0] REG_WDATA,
   input wire [31:0] REG_RDATA,
   input wire        REG_RDATA_VALID,
   // links
   input wire [3:0]  LANE_OK,
   input wire [3:0]  PARTNER_GEN2,
   input wire [3:0]  LINK_UP,
   input wire [3:0]  LINK_GEN2,
   // numbering and clocks
   input wire        UP_DEVNUM_LOAD,
   input wire [4:0]  UP_DEVNUM,
   input wire [19:0] BRIDGE_DEVNUM,
   input wire [2:0]  CLK_OUT_PAIR_EN
);
   // ==========================================
   // properties
   wire [2:0] wr_en_bits = REG_WDATA[10:8];
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   a_rdvalid_pulse: assert property (REG_RDATA_VALID == $past(REG_RD))
      else $error("read answer not one cycle after read");
   a_rdata_hold: assert property (!$past(REG_RD) |-> $stable(REG_RDATA))
      else $error("read data moved without a read");
   a_clken_write: assert property ((REG_WR && REG_ADDR == 12'h1d8 && !CFG_LOAD_DONE)
      |=> CLK_OUT_PAIR_EN == $past(wr_en_bits)) else $error("clock pair enables missed write");
   a_clken_reset: assert property ($fell(SYS_RST) |-> CLK_OUT_PAIR_EN == 3'h7)
      else $error("clock pairs not all enabled after reset");
   a_devnum_down: assert property (BRIDGE_DEVNUM[19:5] == {5'h3, 5'h2, 5'h1})
      else $error("downstream bridge number wrong");
   a_devnum_up: assert property (UP_DEVNUM_LOAD |=> BRIDGE_DEVNUM[4:0] == $past(UP_DEVNUM))
      else $error("upstream bridge number not adopted");
   // the rate flag is registered one cycle behind the link state
   a_gen2_needs: assert property ((LINK_GEN2 & ~($past(LINK_UP) & $past(PARTNER_GEN2))) == 4'h0)
      else $error("fast rate without link or capable partner");
   a_lane_drop: assert property (!LANE_OK[3] [*4] |-> !LINK_UP[3])
      else $error("link kept up on a dead lane");
   c_up0: cover property ($rose(LINK_UP[0]));
   c_gen2: cover property (LINK_GEN2[2]);
   c_down3: cover property ($fell(LINK_UP[3]));
endmodule // plc_port_lane_cfg_chk

bind plc_port_lane_cfg plc_port_lane_cfg_chk i_plc_port_lane_cfg_chk (
   .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CFG_LOAD_DONE(CFG_LOAD_DONE),
   .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
   .REG_RDATA(REG_RDATA), .REG_RDATA_VALID(REG_RDATA_VALID), .LANE_OK(LANE_OK),
   .PARTNER_GEN2(PARTNER_GEN2), .LINK_UP(LINK_UP), .LINK_GEN2(LINK_GEN2),
   .UP_DEVNUM_LOAD(UP_DEVNUM_LOAD), .UP_DEVNUM(UP_DEVNUM),
   .BRIDGE_DEVNUM(BRIDGE_DEVNUM), .CLK_OUT_PAIR_EN(CLK_OUT_PAIR_EN));

// File: verification/plc_port_lane_cfg_tb.sv
// testbench for the port and lane configuration block
`timescale 1ns/1ps
module plc_port_lane_cfg_tb;
   // ==========================================
   // signals
   logic        REF_CLK, SYS_RST, PORT_WIDTH_STRAP, CFG_LOAD_DONE;
   logic        CFG_LOAD_HAS_PORTCFG, CFG_LOAD_PORTCFG, CFG_LOAD_HAS_CLKEN;
   logic [2:0]  CFG_LOAD_CLKEN;
   logic [11:0] REG_ADDR;
   logic        REG_WR, REG_RD, UP_DEVNUM_LOAD;
   logic [31:0] REG_WDATA;
   logic [4:0]  UP_DEVNUM;
   logic [3:0]  GPIO_IN, broken, x2_cap, gen2_cap;
   wire  [31:0] REG_RDATA;
   wire         REG_RDATA_VALID;
   wire  [3:0]  LANE_OK, PARTNER_X2, PARTNER_GEN2, LINK_UP, LINK_GEN2, PORT_CFG_RESPOND;
   wire  [3:0]  GPIO_OUT, GPIO_OE_N;
   wire  [19:0] BRIDGE_DEVNUM;
   wire  [2:0]  CLK_OUT_PAIR_EN;
   integer      n_fail = 0;
   integer      comparisons = 0;
   integer      cyc = 0;

   plc_link_partner i_plc_link_partner (.clk(REF_CLK), .rst(SYS_RST), .broken(broken),
      .x2_cap(x2_cap), .gen2_cap(gen2_cap), .lane_ok(LANE_OK), .partner_x2(PARTNER_X2),
      .partner_gen2(PARTNER_GEN2));
   plc_port_lane_cfg i_plc_port_lane_cfg (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
      .PORT_WIDTH_STRAP(PORT_WIDTH_STRAP), .CFG_LOAD_DONE(CFG_LOAD_DONE),
      .CFG_LOAD_HAS_PORTCFG(CFG_LOAD_HAS_PORTCFG), .CFG_LOAD_PORTCFG(CFG_LOAD_PORTCFG),
      .CFG_LOAD_HAS_CLKEN(CFG_LOAD_HAS_CLKEN), .CFG_LOAD_CLKEN(CFG_LOAD_CLKEN),
      .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA), .REG_RDATA_VALID(REG_RDATA_VALID), .LANE_OK(LANE_OK),
      .PARTNER_X2(PARTNER_X2), .PARTNER_GEN2(PARTNER_GEN2), .LINK_UP(LINK_UP),
      .LINK_GEN2(LINK_GEN2), .PORT_CFG_RESPOND(PORT_CFG_RESPOND),
      .UP_DEVNUM_LOAD(UP_DEVNUM_LOAD), .UP_DEVNUM(UP_DEVNUM), .BRIDGE_DEVNUM(BRIDGE_DEVNUM),
      .CLK_OUT_PAIR_EN(CLK_OUT_PAIR_EN), .GPIO_IN(GPIO_IN), .GPIO_OUT(GPIO_OUT),
      .GPIO_OE_N(GPIO_OE_N));

   // ==========================================
   // tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (n_fail == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wait_cyc(input integer n);
      repeat (n) @(negedge REF_CLK);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(negedge REF_CLK);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'b1;
      @(negedge REF_CLK);
      REG_WR = 1'b0;
   endtask
   // the valid flag stands one cycle only, so it is looked at in that cycle
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(negedge REF_CLK);
      REG_ADDR = a;
      REG_RD = 1'b1;
      @(negedge REF_CLK);
      REG_RD = 1'b0;
      chk({31'h0, REG_RDATA_VALID}, 32'h1);
      chk(REG_RDATA, exp);
   endtask
   task automatic boot(input logic s, input logic hp, input logic p, input logic hc,
                       input logic [2:0] c);
      SYS_RST = 1'b1;
      PORT_WIDTH_STRAP = s;
      CFG_LOAD_HAS_PORTCFG = hp;
      CFG_LOAD_PORTCFG = p;
      CFG_LOAD_HAS_CLKEN = hc;
      CFG_LOAD_CLKEN = c;
      wait_cyc(20);
      SYS_RST = 1'b0;
      wait_cyc(3);
      CFG_LOAD_DONE = 1'b1;
      wait_cyc(1);
      CFG_LOAD_DONE = 1'b0;
   endtask

   // ==========================================
   // clock, timeout and scenarios
   initial begin
      REF_CLK = 1'b0;
      forever #2.5 REF_CLK = ~REF_CLK;
   end
   // whole run is near 5700 cycles; the ceiling leaves ample slack
   always @(posedge REF_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         tally_and_finish;
      end
   end
   initial begin
      {SYS_RST, REG_WR, REG_RD, UP_DEVNUM_LOAD, CFG_LOAD_DONE} = 5'h10;
      {REG_ADDR, REG_WDATA, UP_DEVNUM, GPIO_IN, broken} = 57'h0;
      x2_cap = 4'hf;
      gen2_cap = 4'h5;
      boot(1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
      wait_cyc(600);
      rd(12'h1e4, 32'h0000190a);
      chk({28'h0, PORT_CFG_RESPOND}, 32'hd);
      chk({28'h0, LINK_GEN2}, 32'h5);
      chk({28'h0, LINK_UP}, 32'hd);
      rd(12'h1d8, 32'h700);
      wr(12'h1d8, 32'h500);
      rd(12'h1d8, 32'h500);
      chk({29'h0, CLK_OUT_PAIR_EN}, 32'h5);
      wr(12'h100, 32'hffffffff);
      rd(12'h100, 32'h0);
      UP_DEVNUM = 5'h05;
      UP_DEVNUM_LOAD = 1'b1;
      wait_cyc(1);
      UP_DEVNUM_LOAD = 1'b0;
      rd(12'h1f4, 32'h00018825);
      broken = 4'h2;
      wait_cyc(1000);
      rd(12'h1e4, 32'h00001909);
      broken = 4'h9;
      wait_cyc(1400);
      rd(12'h1e4, 32'h0000090d);
      chk({28'h0, LINK_UP}, 32'h5);
      broken = 4'h0;
      x2_cap = 4'he;
      wr(12'h1e0, 32'h00000ff1);
      wait_cyc(1000);
      rd(12'h1e4, 32'h00001909);
      wr(12'h1e0, 32'h00000b70);
      wait_cyc(1000);
      rd(12'h1e4, 32'h00000119);
      chk({28'h0, PORT_CFG_RESPOND}, 32'h7);
      wr(12'h1e8, 32'h00002011);
      wait_cyc(3);
      chk({30'h0, GPIO_OE_N[0], GPIO_OUT[0]}, 32'h1);
      GPIO_IN = 4'h2;
      wait_cyc(4);
      rd(12'h1f0, 32'h2);
      wr(12'h1f0, 32'h2);
      rd(12'h1f0, 32'h0);
      wr(12'h1ec, 32'h00000000);
      wr(12'h1e8, 32'h00000111);
      wait_cyc(3);
      chk({31'h0, GPIO_OUT[0]}, 32'h0);
      wr(12'h1ec, 32'h0000ff00);
      wait_cyc(3);
      chk({31'h0, GPIO_OUT[0]}, 32'h1);
      boot(1'b1, 1'b1, 1'b0, 1'b1, 3'h2);
      wait_cyc(600);
      rd(12'h1e4, 32'h00011919);
      chk({29'h0, CLK_OUT_PAIR_EN}, 32'h2);
      tally_and_finish;
   end
endmodule // plc_port_lane_cfg_tb
